// [design/swi_timing_map.svh]
`ifndef SWI_TIMING_MAP_SVH
`define SWI_TIMING_MAP_SVH

// clock rate
`define SWI_CLK_MHZ               40

// active glitch limit in ns, sleep glitch limit in us
`define SWI_ACTIVE_GLITCH_NS      45
`define SWI_SLEEP_GLITCH_US       15

// device transmit timing, nominal figures in us
`define SWI_START_PULSE_US        6
`define SWI_BIT_PERIOD_US         54
`define SWI_DIR_CHANGE_US         96

// receive decision window after a start fall, in us
`define SWI_RX_WINDOW_US          20

// long limits in ms
`define SWI_LINE_IDLE_MS          65
`define SWI_WAKE_WATCHDOG_MS      1300

// derived cycle counts; least times round up
`define SWI_ACTIVE_GLITCH_CYC     ((`SWI_ACTIVE_GLITCH_NS * `SWI_CLK_MHZ + 999) / 1000)
`define SWI_SLEEP_GLITCH_CYC      (`SWI_SLEEP_GLITCH_US * `SWI_CLK_MHZ)
`define SWI_START_PULSE_CYC       (`SWI_START_PULSE_US * `SWI_CLK_MHZ)
`define SWI_BIT_PERIOD_CYC        (`SWI_BIT_PERIOD_US * `SWI_CLK_MHZ)
`define SWI_DIR_CHANGE_CYC        (`SWI_DIR_CHANGE_US * `SWI_CLK_MHZ)
`define SWI_RX_WINDOW_CYC         (`SWI_RX_WINDOW_US * `SWI_CLK_MHZ)
`define SWI_LINE_IDLE_CYC         (`SWI_LINE_IDLE_MS * `SWI_CLK_MHZ * 1000)
`define SWI_WAKE_WATCHDOG_CYC     (`SWI_WAKE_WATCHDOG_MS * `SWI_CLK_MHZ * 1000)

`endif

// [design/swi_timing_pkg.sv]
package swi_timing_pkg;

  typedef enum logic [1:0] {
    ST_SLEEP = 2'b00,
    ST_IDLE  = 2'b01,
    ST_TX    = 2'b10
  } swi_state_t;

endpackage

// [design/swi_two_entry_buffer.sv]
`timescale 1ns/1ps
`default_nettype none

module swi_two_entry_buffer #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  logic [WIDTH-1:0] head_q;
  logic [WIDTH-1:0] spare_q;
  logic             head_v_q;
  logic             spare_v_q;

  wire pop  = head_v_q & out_ready;
  wire push = in_valid & ~spare_v_q;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      head_v_q  <= 1'b0;
      spare_v_q <= 1'b0;
      head_q    <= '0;
      spare_q   <= '0;
    end else if (pop && spare_v_q) begin
      head_q    <= spare_q;
      spare_v_q <= 1'b0;
    end else if (pop) begin
      head_v_q <= push;
      if (push) begin
        head_q <= in_data;
      end
    end else if (push && !head_v_q) begin
      head_q   <= in_data;
      head_v_q <= 1'b1;
    end else if (push) begin
      spare_q   <= in_data;
      spare_v_q <= 1'b1;
    end
  end

  // ready depends only on the spare slot, so it is a registered level
  assign in_ready  = ~spare_v_q;
  assign out_valid = head_v_q;
  assign out_data  = head_q;

endmodule

`default_nettype wire

// [design/single_wire_wake_and_bit_timing.sv]
// Summary of operation
// - when awake, line pulses shorter than 45 ns are ignored.
// - when asleep, low pulses shorter than 15 us do not wake the device.
// - watchdog from wake forces sleep between 0.7 and 1.7 s, typically 1.3 s.
// - device start, zero-high and zero-low pulses last 4.60 to 8.60 us.
// - device first low falls 64 to 131 us after host's last start fall.
// - line idle for 45 to 85 ms sends the device back to sleep.
// - timing fits a 230.4 kbaud seven-bit UART on either end.
`timescale 1ns/1ps
`default_nettype none
`include "swi_timing_map.svh"

module single_wire_wake_and_bit_timing #(
  parameter int unsigned LINE_IDLE_CYC     = `SWI_LINE_IDLE_CYC,
  parameter int unsigned WAKE_WATCHDOG_CYC = `SWI_WAKE_WATCHDOG_CYC
) (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic line_i,
  output logic      line_o,
  output logic      line_oe,
  input  wire logic tx_valid,
  input  wire logic tx_bit,
  output logic      tx_ready,
  output logic      rx_valid,
  output logic      rx_bit,
  input  wire logic rx_ready,
  output logic      rx_overflow,
  output logic      awake
);

  localparam logic [31:0] ACT_GLITCH = 32'(`SWI_ACTIVE_GLITCH_CYC);
  localparam logic [31:0] SLP_GLITCH = 32'(`SWI_SLEEP_GLITCH_CYC);
  localparam logic [31:0] PULSE      = 32'(`SWI_START_PULSE_CYC);
  localparam logic [31:0] BIT_PER    = 32'(`SWI_BIT_PERIOD_CYC);
  localparam logic [31:0] TURN       = 32'(`SWI_DIR_CHANGE_CYC);
  localparam logic [31:0] RX_WIN     = 32'(`SWI_RX_WINDOW_CYC);
  localparam logic [31:0] IDLE_LIM   = 32'(LINE_IDLE_CYC);
  localparam logic [31:0] WDOG_LIM   = 32'(WAKE_WATCHDOG_CYC);

  swi_timing_pkg::swi_state_t st_q;
  swi_timing_pkg::swi_state_t st_d;

  logic        sync1_q;
  logic        sync2_q;
  logic        sync3_q;
  logic        filt_q;
  logic        filt_prev_q;
  logic [31:0] glitch_q;
  logic [31:0] wdog_q;
  logic [31:0] idle_q;
  logic [31:0] tcnt_q;
  logic [31:0] rcnt_q;
  logic [31:0] since_fall_q;
  logic        tx_bit_q;
  logic        last_tx_q;
  logic        rx_active_q;
  logic        tx_ready_q;
  logic        line_oe_q;
  logic        line_o_q;
  logic        ovf_q;
  logic        awake_q;
  logic        buf_in_ready;

  // synchroniser; only the second and third stage are looked at beyond this
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      sync3_q <= 1'b1;
    end else begin
      sync1_q <= line_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // a change counts only while stages two and three agree
  wire         agree_w    = (sync2_q == sync3_q);
  wire         differs_w  = agree_w && (sync3_q != filt_q);
  wire         sleeping_w = (st_q == swi_timing_pkg::ST_SLEEP);
  // asleep only the low level is filtered long; rising back is taken at once
  wire  [31:0] glim_w     = sleeping_w ? (sync3_q ? 32'h0000_0001 : SLP_GLITCH)
                                       : ACT_GLITCH;
  wire  [31:0] glitch_n_w = glitch_q + 32'h0000_0001;
  wire         accept_w   = differs_w && (glitch_n_w >= glim_w);

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      filt_q      <= 1'b1;
      filt_prev_q <= 1'b1;
      glitch_q    <= 32'h0000_0000;
    end else begin
      filt_prev_q <= filt_q;
      if (accept_w) begin
        filt_q   <= sync3_q;
        glitch_q <= 32'h0000_0000;
      end else if (differs_w) begin
        glitch_q <= glitch_n_w;
      end else begin
        glitch_q <= 32'h0000_0000;
      end
    end
  end

  wire fall_w = filt_prev_q & ~filt_q;
  wire edge_w = filt_prev_q ^ filt_q;

  // timeouts while awake
  wire wdog_hit_w = !sleeping_w && (wdog_q >= WDOG_LIM - 32'h0000_0001);
  wire idle_hit_w = (st_q == swi_timing_pkg::ST_IDLE) && !tx_valid
                    && (idle_q >= IDLE_LIM - 32'h0000_0001);

  // receive decode: start fall opens a bit, a second fall inside the window is a zero
  wire rx_open_w  = (st_q == swi_timing_pkg::ST_IDLE) && fall_w && !rx_active_q;
  wire rx_zero_w  = (st_q == swi_timing_pkg::ST_IDLE) && fall_w && rx_active_q;
  wire rx_one_w   = (st_q == swi_timing_pkg::ST_IDLE) && rx_active_q && !fall_w
                    && (rcnt_q >= RX_WIN - 32'h0000_0001);
  wire rx_emit_w  = rx_zero_w || rx_one_w;

  // first bit after a host flag waits out the direction change delay
  wire turn_ok_w  = last_tx_q || (since_fall_q >= TURN - 32'h0000_0001);
  wire tx_take_w  = tx_valid && tx_ready_q;
  wire tx_end_w   = (st_q == swi_timing_pkg::ST_TX) && (tcnt_q >= BIT_PER - 32'h0000_0001);

  // drive low for the start pulse, and for the second low of a zero
  // released when the watchdog fires so the line never stays pulled once asleep
  wire drive_w    = (st_q == swi_timing_pkg::ST_TX) && !tx_end_w && !wdog_hit_w
                    && ((tcnt_q < PULSE)
                    || (!tx_bit_q && tcnt_q >= PULSE + PULSE
                        && tcnt_q < PULSE + PULSE + PULSE));

  always_comb begin
    st_d = st_q;
    case (st_q)
      swi_timing_pkg::ST_SLEEP: begin
        if (fall_w) begin
          st_d = swi_timing_pkg::ST_IDLE;
        end
      end
      swi_timing_pkg::ST_IDLE: begin
        if (wdog_hit_w || idle_hit_w) begin
          st_d = swi_timing_pkg::ST_SLEEP;
        end else if (tx_take_w) begin
          st_d = swi_timing_pkg::ST_TX;
        end
      end
      swi_timing_pkg::ST_TX: begin
        if (wdog_hit_w) begin
          st_d = swi_timing_pkg::ST_SLEEP;
        end else if (tx_end_w) begin
          st_d = swi_timing_pkg::ST_IDLE;
        end
      end
      default: begin
        st_d = swi_timing_pkg::ST_SLEEP;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_q <= swi_timing_pkg::ST_SLEEP;
    end else begin
      st_q <= st_d;
    end
  end

  // watchdog runs from wake regardless of traffic
  always_ff @(posedge ref_clk) begin
    if (!rstn || sleeping_w) begin
      wdog_q <= 32'h0000_0000;
    end else begin
      wdog_q <= wdog_q + 32'h0000_0001;
    end
  end

  // inactivity counter; own transmission counts as activity
  always_ff @(posedge ref_clk) begin
    if (!rstn || sleeping_w || edge_w || st_q == swi_timing_pkg::ST_TX) begin
      idle_q <= 32'h0000_0000;
    end else begin
      idle_q <= idle_q + 32'h0000_0001;
    end
  end

  // time since the last host start fall, saturating at the turnaround count TURN
  always_ff @(posedge ref_clk) begin
    if (!rstn || rx_open_w) begin
      since_fall_q <= 32'h0000_0000;
    end else if (since_fall_q < TURN) begin
      since_fall_q <= since_fall_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn || st_q != swi_timing_pkg::ST_IDLE || rx_open_w) begin
      rcnt_q <= 32'h0000_0000;
    end else if (rx_active_q) begin
      rcnt_q <= rcnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn || st_q != swi_timing_pkg::ST_IDLE) begin
      rx_active_q <= 1'b0;
    end else if (rx_open_w) begin
      rx_active_q <= 1'b1;
    end else if (rx_emit_w) begin
      rx_active_q <= 1'b0;
    end
  end

  // transmit slot counter and direction bookkeeping
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tcnt_q    <= 32'h0000_0000;
      tx_bit_q  <= 1'b1;
      last_tx_q <= 1'b0;
    end else begin
      if (tx_take_w) begin
        tcnt_q    <= 32'h0000_0000;
        tx_bit_q  <= tx_bit;
        last_tx_q <= 1'b1;
      end else if (st_q == swi_timing_pkg::ST_TX) begin
        tcnt_q <= tcnt_q + 32'h0000_0001;
      end
      if (rx_open_w || sleeping_w) begin
        last_tx_q <= 1'b0;
      end
    end
  end

  // ready only in idle with no host bit in progress; drops the cycle it is taken
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tx_ready_q <= 1'b0;
    end else begin
      tx_ready_q <= (st_d == swi_timing_pkg::ST_IDLE) && (st_q == swi_timing_pkg::ST_IDLE)
                    && !tx_take_w && !rx_active_q && !rx_open_w && turn_ok_w;
    end
  end

  // open-drain style: the line is only ever pulled low
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      line_oe_q <= 1'b0;
      line_o_q  <= 1'b0;
      awake_q   <= 1'b0;
    end else begin
      line_oe_q <= drive_w;
      line_o_q  <= 1'b0;
      awake_q   <= (st_d != swi_timing_pkg::ST_SLEEP);
    end
  end

  // the line cannot be stalled, so a full buffer is reported and the bit dropped
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ovf_q <= 1'b0;
    end else if (rx_emit_w && !buf_in_ready) begin
      ovf_q <= 1'b1;
    end else if (sleeping_w) begin
      ovf_q <= 1'b0;
    end
  end

  swi_two_entry_buffer #(
    .WIDTH (1)
  ) u_rx_buf (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .in_valid  (rx_emit_w),
    .in_data   (rx_one_w),
    .in_ready  (buf_in_ready),
    .out_valid (rx_valid),
    .out_data  (rx_bit),
    .out_ready (rx_ready)
  );

  assign line_o      = line_o_q;
  assign line_oe     = line_oe_q;
  assign tx_ready    = tx_ready_q;
  assign rx_overflow = ovf_q;
  assign awake       = awake_q;

endmodule

`default_nettype wire

// [testbench/swi_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module swi_host_model (
  input  wire logic ref_clk,
  input  wire logic dev_oe,
  output logic      line
);
  logic pull_q = 1'b0;

  // pulled up: a released line reads high, never the last driven value
  assign line = ~(pull_q | dev_oe);

  task automatic hold(input logic low, input int n);
    pull_q = low;
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic wake();
    hold(1'b0, 4000);
    hold(1'b1, 2400);
    hold(1'b0, 60000);
  endtask

  // 174 cycles is one 230.4 kbaud bit time, inside the accepted pulse band
  task automatic send_bit(input logic b);
    hold(1'b1, 174);
    if (!b) begin
      hold(1'b0, 174);
      hold(1'b1, 174);
    end
    hold(1'b0, b ? 1386 : 1038);
  endtask
endmodule

`default_nettype wire

// [testbench/single_wire_wake_and_bit_timing_sva.sv]
`timescale 1ns/1ps
`default_nettype none

module swi_wake_checker #(
  parameter int unsigned LINE_IDLE_CYC     = 1,
  parameter int unsigned WAKE_WATCHDOG_CYC = 1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic line_i,
  input wire logic line_o,
  input wire logic line_oe,
  input wire logic tx_valid,
  input wire logic tx_bit,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic rx_bit,
  input wire logic rx_ready,
  input wire logic rx_overflow,
  input wire logic awake
);
  int unsigned hi_q, lo_q, sh_q, lw_q, wd_q, id_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // sh_q: cycles since the host last pulled the line down
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      {hi_q, lo_q, sh_q, lw_q, wd_q, id_q} <= '0;
    end else begin
      hi_q <= line_oe ? hi_q + 1 : 0;
      lo_q <= line_oe ? 0 : lo_q + 1;
      sh_q <= ($fell(line_i) && !line_oe) ? 0 : sh_q + 1;
      lw_q <= line_i ? 0 : lw_q + 1;
      wd_q <= awake ? wd_q + 1 : 0;
      id_q <= (!awake || line_oe || tx_valid || $changed(line_i)) ? 0 : id_q + 1;
    end
  end

  line_o_low_a: assert property (!line_o) else $error("line driven high");
  sleep_quiet_a: assert property (!awake |-> !line_oe) else $error("drive asleep");
  wake_filter_a: assert property ($rose(awake) |-> lw_q >= 600)
    else $error("woke on short low");
  pulse_width_a: assert property ($fell(line_oe) && awake |-> hi_q >= 184 && hi_q <= 344)
    else $error("low pulse width");
  zero_high_a: assert property ($rose(line_oe) && lo_q < 1000 |-> lo_q >= 184 && lo_q <= 344)
    else $error("zero high width");
  turn_delay_a: assert property ($rose(line_oe) |-> sh_q >= 2560)
    else $error("turnaround too short");
  watchdog_limit_a: assert property (wd_q <= WAKE_WATCHDOG_CYC + 4)
    else $error("watchdog late");
  idle_limit_a: assert property (id_q <= LINE_IDLE_CYC + 16)
    else $error("idle timeout late");
  rx_hold_a: assert property (rx_valid && !rx_ready && awake |=>
    !awake || (rx_valid && $stable(rx_bit))) else $error("rx bit lost");

  cover property ($rose(awake));
  cover property (rx_valid && rx_ready);
  cover property ($fell(awake));
endmodule

bind single_wire_wake_and_bit_timing swi_wake_checker #(
  .LINE_IDLE_CYC     (LINE_IDLE_CYC),
  .WAKE_WATCHDOG_CYC (WAKE_WATCHDOG_CYC)
) chk_inst (
  .ref_clk     (ref_clk),
  .rstn        (rstn),
  .line_i      (line_i),
  .line_o      (line_o),
  .line_oe     (line_oe),
  .tx_valid    (tx_valid),
  .tx_bit      (tx_bit),
  .tx_ready    (tx_ready),
  .rx_valid    (rx_valid),
  .rx_bit      (rx_bit),
  .rx_ready    (rx_ready),
  .rx_overflow (rx_overflow),
  .awake       (awake)
);

`default_nettype wire

// [testbench/single_wire_wake_and_bit_timing_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module single_wire_wake_and_bit_timing_tb_top;
  localparam int unsigned IDLE = 32'h11170;
  localparam int unsigned WDOG = 32'h15f90;
  logic ref_clk = 1'b0, rstn = 1'b0, tx_valid = 1'b0, tx_bit = 1'b0, rx_ready = 1'b0;
  logic line_o, line_oe, tx_ready, rx_valid, rx_bit, rx_overflow, awake, oe_q = 1'b0;
  wire logic line_w;
  int n_errors = 0, compares = 0, cyc = 0, wake_t = 0;
  int rises[$];

  always #12.5 ref_clk = ~ref_clk;
  always @(posedge awake) wake_t = cyc;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    oe_q <= line_oe;
    if (line_oe && !oe_q) rises.push_back(cyc);
  end

  swi_host_model swi_host_model_inst (.ref_clk(ref_clk), .dev_oe(line_oe), .line(line_w));

  // idle limit sits above the 1500 us wake high so waking alone cannot time out
  single_wire_wake_and_bit_timing #(
    .LINE_IDLE_CYC     (IDLE),
    .WAKE_WATCHDOG_CYC (WDOG)
  ) single_wire_wake_and_bit_timing_inst (
    .ref_clk(ref_clk), .rstn(rstn), .line_i(line_w), .line_o(line_o), .line_oe(line_oe),
    .tx_valid(tx_valid), .tx_bit(tx_bit), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_bit(rx_bit), .rx_ready(rx_ready), .rx_overflow(rx_overflow), .awake(awake)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic pop(input logic b);
    int k = 0;
    while (rx_valid !== 1'b1 && k < 900) begin
      @(negedge ref_clk);
      k++;
    end
    check(rx_valid, 1'b1);
    check(rx_bit, b);
    rx_ready = 1'b1;
    @(negedge ref_clk);
    rx_ready = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic send(input logic b);
    int k = 0;
    tx_valid = 1'b1;
    tx_bit = b;
    // ready is looked at on the falling edge; the next rising edge takes the bit
    while (tx_ready !== 1'b1 && k < 9000) begin
      @(negedge ref_clk);
      k++;
    end
    check(tx_ready, 1'b1);
    @(negedge ref_clk);
    tx_valid = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic t_wake();
    swi_host_model_inst.hold(1'b1, 500);
    swi_host_model_inst.hold(1'b0, 700);
    check(awake, 1'b0);
    swi_host_model_inst.wake();
    check(awake, 1'b1);
  endtask

  task automatic t_rx();
    swi_host_model_inst.hold(1'b1, 1);
    swi_host_model_inst.hold(1'b0, 1000);
    check(rx_valid, 1'b0);
    swi_host_model_inst.send_bit(1'b1);
    pop(1'b1);
    swi_host_model_inst.send_bit(1'b0);
    pop(1'b0);
  endtask

  task automatic t_tx();
    int t0 = cyc;
    rises.delete();
    swi_host_model_inst.send_bit(1'b1);
    pop(1'b1);
    send(1'b0);
    send(1'b1);
    repeat (3720) @(negedge ref_clk);
    check(rises.size(), 3);
    check(rises[0] - t0 >= 2560 && rises[0] - t0 <= 5240, 1'b1);
    check(rises[1] - rises[0] >= 368 && rises[1] - rises[0] <= 688, 1'b1);
    check(rises[2] - rises[0] >= 1640 && rises[2] - rises[0] <= 3120, 1'b1);
  endtask

  task automatic t_overflow();
    repeat (3) swi_host_model_inst.send_bit(1'b1);
    check(rx_overflow, 1'b1);
    pop(1'b1);
    pop(1'b1);
    check(rx_valid, 1'b0);
  endtask

  task automatic t_watchdog();
    int k = 0;
    while (awake === 1'b1 && k < 40000) begin
      @(negedge ref_clk);
      k++;
    end
    check(cyc - wake_t >= WDOG - 8 && cyc - wake_t <= WDOG + 8, 1'b1);
  endtask

  initial begin
    repeat (5) @(negedge ref_clk);
    rstn = 1'b1;
    t_wake();
    t_rx();
    t_tx();
    t_overflow();
    t_watchdog();
    give_verdict();
  end

  // whole run ends near 96k cycles when the watchdog sends the device to sleep
  initial begin
    #2475000;
    n_errors++;
    give_verdict();
  end
endmodule

`default_nettype wire
